// [sgm_status_gpio_mapper.sv]
// Status GPIO mapper: per-bit output and input mode logic with an APB register file.
`timescale 1ns/10ps
`include "sgm_defines.svh"

module sgm_status_gpio_mapper #(
	parameter int N_BITS     = 8,
	parameter int PULSE_CYC  = `SGM_PULSE_CYC,
	parameter int PERIOD_CYC = `SGM_PERIOD_CYC,
	parameter int CNT_W      = 16
) (
	input  wire logic                 pclk,              // System clock, 100 MHz.
	input  wire logic                 presetn,           // Asynchronous reset, active low.
	input  wire logic                 psel,              // APB select.
	input  wire logic                 penable,           // APB enable.
	input  wire logic                 pwrite,            // APB write.
	input  wire logic [11:0]          paddr,             // APB byte address.
	input  wire logic [31:0]          pwdata,            // APB write data.
	output logic      [31:0]          prdata,            // APB read data.
	output logic                      pready,            // APB ready.
	output logic                      pslverr,           // APB error on unmapped address.
	input  wire logic [N_BITS-1:0]    par_in_n,          // Parallel port inputs, active low.
	output logic      [N_BITS-1:0]    par_out_o,         // Parallel output drive level, always low.
	output logic      [N_BITS-1:0]    par_out_oe,        // Parallel open-collector pull-down enable.
	input  wire logic [9:0]           net_in_chan,       // Network status in channels 1 and 2, five bits each.
	output logic      [9:0]           net_out_chan,      // Network status out channels 1 and 2, five bits each.
	input  sgm_pkg::sgm_call_evt_t    call_evt,          // Call and decoder events, same clock.
	input  wire logic [N_BITS-1:0]    remote_in,         // Far-end input bits from the ancillary channel.
	input  wire logic                 remote_valid,      // Far end supports mirrored contact closures.
	output logic      [N_BITS-1:0]    remote_out,        // Input bits sent to the far end.
	output sgm_pkg::sgm_call_cmd_t    call_cmd           // Disconnect and dial requests.
);

	// ----------------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------------
	logic [31:0]      out_mode_reg;
	logic [31:0]      in_mode_reg;
	logic [1:0]       ctrl_reg;
	logic [CNT_W-1:0] thresh_reg;
	logic             wr_en;
	logic             addr_ok;
	logic             cancel_pulse;

	function automatic logic [3:0] nib(input logic [31:0] v, input int i);
		nib = v[i*4 +: 4];
	endfunction : nib

	assign wr_en  = psel && penable && pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			`SGM_OUT_MODE_OFF, `SGM_IN_MODE_OFF, `SGM_CTRL_OFF, `SGM_THRESH_OFF,
			`SGM_STATUS_OFF, `SGM_REMOTE_OFF, `SGM_IN_STATE_OFF, `SGM_BAD_COUNT_OFF: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr      = psel && penable && !addr_ok;
	assign cancel_pulse = wr_en && (paddr == `SGM_CTRL_OFF) && pwdata[`SGM_CTRL_CANCEL];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_mode_reg <= `SGM_OUT_MODE_RST;
			in_mode_reg  <= `SGM_IN_MODE_RST;
			ctrl_reg     <= 2'h0;
			thresh_reg   <= `SGM_THRESH_RST;
		end else if (wr_en) begin
			case (paddr)
				`SGM_OUT_MODE_OFF: out_mode_reg <= pwdata;
				`SGM_IN_MODE_OFF:  in_mode_reg  <= pwdata;
				`SGM_CTRL_OFF:     ctrl_reg     <= {1'b0, pwdata[`SGM_CTRL_SRC_NET]};
				`SGM_THRESH_OFF:   thresh_reg   <= pwdata[CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Input capture
	// ----------------------------------------------------------------------
	logic [N_BITS-1:0] par_meta_reg;
	logic [N_BITS-1:0] par_sync_reg;
	logic [N_BITS-1:0] net_meta_reg;
	logic [N_BITS-1:0] net_sync_reg;
	logic [N_BITS-1:0] in_level;
	logic [N_BITS-1:0] in_prev_reg;
	logic [N_BITS-1:0] in_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_meta_reg <= '0;
			par_sync_reg <= '0;
			net_meta_reg <= '0;
			net_sync_reg <= '0;
		end else begin
			par_meta_reg <= ~par_in_n;
			par_sync_reg <= par_meta_reg;
			net_meta_reg <= {net_in_chan[8:5], net_in_chan[3:0]};
			net_sync_reg <= net_meta_reg;
		end
	end

	assign in_level = ctrl_reg[`SGM_CTRL_SRC_NET] ? net_sync_reg : par_sync_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_prev_reg <= '0;
		end else begin
			in_prev_reg <= in_level;
		end
	end
	assign in_rise = in_level & ~in_prev_reg;

	// ----------------------------------------------------------------------
	// Input modes
	// ----------------------------------------------------------------------
	logic [N_BITS-1:0]   remote_next;
	logic                disc_next;
	logic                dial_next;
	logic [2:0]          entry_next;

	always_comb begin
		remote_next = '0;
		disc_next   = 1'b0;
		dial_next   = 1'b0;
		entry_next  = 3'h0;
		for (int i = N_BITS - 1; i >= 0; i--) begin
			case (sgm_pkg::sgm_in_mode_t'(nib(in_mode_reg, i)))
				sgm_pkg::SGM_IN_REMOTE_MIRROR: remote_next[i] = in_level[i];
				sgm_pkg::SGM_IN_DISCONNECT: begin
					if (in_rise[i] && call_evt.connected) begin
						disc_next = 1'b1;
					end
				end
				sgm_pkg::SGM_IN_EMERG_DIAL: begin
					if (in_rise[i]) begin
						dial_next  = 1'b1;
						entry_next = 3'(i);
					end
				end
				sgm_pkg::SGM_IN_FORCE_ZERO: remote_next[i] = 1'b0;
				sgm_pkg::SGM_IN_FORCE_ONE:  remote_next[i] = 1'b1;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_out <= '0;
			call_cmd   <= '0;
		end else begin
			remote_out          <= remote_next;
			call_cmd.disconnect <= disc_next;
			call_cmd.dial       <= dial_next;
			call_cmd.dial_entry <= entry_next;
		end
	end

	// ----------------------------------------------------------------------
	// Call-drop latch, packet-loss pulse and poor-link window
	// ----------------------------------------------------------------------
	logic                         dropped_reg;
	logic [$clog2(PULSE_CYC+1)-1:0] pulse_cnt_reg;
	logic [$clog2(PERIOD_CYC+1)-1:0] period_cnt_reg;
	logic [CNT_W-1:0]             bad_cnt_reg;
	logic                         poor_reg;
	logic                         period_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dropped_reg <= 1'b0;
		end else if (call_evt.call_dropped) begin
			dropped_reg <= 1'b1;
		end else if (call_evt.connected || cancel_pulse) begin
			dropped_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_cnt_reg <= '0;
		end else if (call_evt.pkt_lost) begin
			pulse_cnt_reg <= ($clog2(PULSE_CYC+1))'(PULSE_CYC);
		end else if (pulse_cnt_reg != '0) begin
			pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
		end
	end

	assign period_tick = (period_cnt_reg == ($clog2(PERIOD_CYC+1))'(PERIOD_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_cnt_reg <= '0;
		end else if (period_tick) begin
			period_cnt_reg <= '0;
		end else begin
			period_cnt_reg <= period_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bad_cnt_reg <= '0;
			poor_reg    <= 1'b0;
		end else if (period_tick) begin
			poor_reg    <= (bad_cnt_reg >= thresh_reg);
			bad_cnt_reg <= '0;
		end else if ((call_evt.pkt_lost || call_evt.pkt_errored) && bad_cnt_reg != '1) begin
			bad_cnt_reg <= bad_cnt_reg + 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Output modes
	// ----------------------------------------------------------------------
	logic [N_BITS-1:0] out_next;
	logic [N_BITS-1:0] out_reg;

	always_comb begin
		out_next = '0;
		for (int i = 0; i < N_BITS; i++) begin
			case (sgm_pkg::sgm_out_mode_t'(nib(out_mode_reg, i)))
				sgm_pkg::SGM_OUT_OFF:   out_next[i] = 1'b0;
				sgm_pkg::SGM_OUT_ON:    out_next[i] = 1'b1;
				sgm_pkg::SGM_OUT_REMOTE_MIRROR:
					out_next[i] = call_evt.connected && remote_valid && remote_in[i];
				sgm_pkg::SGM_OUT_CONNECTED: out_next[i] = call_evt.connected;
				sgm_pkg::SGM_OUT_RX_LOCK:
					out_next[i] = call_evt.connected && call_evt.codec_known && call_evt.rx_valid;
				sgm_pkg::SGM_OUT_FOLLOW_IN: out_next[i] = in_level[i];
				sgm_pkg::SGM_OUT_CALL_DROP: out_next[i] = dropped_reg;
				sgm_pkg::SGM_OUT_PKT_LOSS:  out_next[i] = (pulse_cnt_reg != '0);
				sgm_pkg::SGM_OUT_POOR_LINK: out_next[i] = poor_reg;
				default: out_next[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= '0;
		end else begin
			out_reg <= out_next;
		end
	end

	assign par_out_o    = '0;
	assign par_out_oe   = out_reg;
	assign net_out_chan = {1'b0, out_reg[7:4], 1'b0, out_reg[3:0]};

	// ----------------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------------
	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			case (paddr)
				`SGM_OUT_MODE_OFF:  prdata = out_mode_reg;
				`SGM_IN_MODE_OFF:   prdata = in_mode_reg;
				`SGM_CTRL_OFF:      prdata = {31'h0, ctrl_reg[`SGM_CTRL_SRC_NET]};
				`SGM_THRESH_OFF:    prdata = 32'(thresh_reg);
				`SGM_STATUS_OFF:    prdata = {7'h00, poor_reg, out_reg, in_level,
					5'h0, dropped_reg, call_evt.codec_known && call_evt.rx_valid, call_evt.connected};
				`SGM_REMOTE_OFF:    prdata = {16'h0, remote_in, remote_out};
				`SGM_IN_STATE_OFF:  prdata = 32'(in_level);
				`SGM_BAD_COUNT_OFF: prdata = 32'(bad_cnt_reg);
				default:            prdata = 32'h0000_0000;
			endcase
		end
	end

endmodule : sgm_status_gpio_mapper

// [sgm_defines.svh]
// Constants for the status GPIO mapper: register offsets, field layouts, reset values and timing counts.
`ifndef SGM_DEFINES_SVH
`define SGM_DEFINES_SVH

`define SGM_OUT_MODE_OFF   12'h000
`define SGM_IN_MODE_OFF    12'h004
`define SGM_CTRL_OFF       12'h008
`define SGM_THRESH_OFF     12'h00C
`define SGM_STATUS_OFF     12'h010
`define SGM_REMOTE_OFF     12'h014
`define SGM_IN_STATE_OFF   12'h018
`define SGM_BAD_COUNT_OFF  12'h01C

`define SGM_OUT_MODE_W     4
`define SGM_IN_MODE_W      4
`define SGM_OUT_MODE_RST   32'h0000_0000
`define SGM_IN_MODE_RST    32'h0000_0000
`define SGM_THRESH_RST     16'h0010

`define SGM_CTRL_SRC_NET   0
`define SGM_CTRL_CANCEL    1

`define SGM_STAT_CONNECTED 0
`define SGM_STAT_RX_LOCK   1
`define SGM_STAT_DROPPED   2

`define SGM_PULSE_NS       1000000
`define SGM_PULSE_CYC      (`SGM_PULSE_NS / 10)
`define SGM_PERIOD_MS      3000
`define SGM_PERIOD_CYC     (`SGM_PERIOD_MS * 100000)

`endif

// [sgm_pkg.sv]
// Types shared by the status GPIO mapper.
package sgm_pkg;

	typedef enum logic [3:0] {
		SGM_OUT_OFF,
		SGM_OUT_ON,
		SGM_OUT_REMOTE_MIRROR,
		SGM_OUT_CONNECTED,
		SGM_OUT_RX_LOCK,
		SGM_OUT_FOLLOW_IN,
		SGM_OUT_CALL_DROP,
		SGM_OUT_PKT_LOSS,
		SGM_OUT_POOR_LINK
	} sgm_out_mode_t;

	typedef enum logic [3:0] {
		SGM_IN_UNUSED,
		SGM_IN_REMOTE_MIRROR,
		SGM_IN_DISCONNECT,
		SGM_IN_EMERG_DIAL,
		SGM_IN_FORCE_ZERO,
		SGM_IN_FORCE_ONE
	} sgm_in_mode_t;

	typedef struct packed {
		logic connected;
		logic codec_known;
		logic rx_valid;
		logic call_dropped;
		logic pkt_lost;
		logic pkt_errored;
	} sgm_call_evt_t;

	typedef struct packed {
		logic       disconnect;
		logic       dial;
		logic [2:0] dial_entry;
	} sgm_call_cmd_t;

endpackage : sgm_pkg

// [sgm_status_gpio_mapper_asserts.sv]
// Port checker for the status GPIO mapper.
`timescale 1ns/10ps
`include "sgm_defines.svh"
module sgm_checker #(
	parameter int N_BITS = 8
) (
	input wire logic              pclk,         // Clock.
	input wire logic              presetn,      // Reset, active low.
	input wire logic              psel,         // APB select.
	input wire logic              penable,      // APB enable.
	input wire logic              pwrite,       // APB write.
	input wire logic [11:0]       paddr,        // APB address.
	input wire logic [31:0]       pwdata,       // APB write data.
	input wire logic              pslverr,      // APB error.
	input wire logic [N_BITS-1:0] par_out_o,    // Pin drive level.
	input wire logic [N_BITS-1:0] par_out_oe,   // Pull-down enable.
	input wire logic [9:0]        net_out_chan, // Network outputs.
	input wire logic [N_BITS-1:0] remote_out,   // Bits to far end.
	input sgm_pkg::sgm_call_cmd_t call_cmd      // Call requests.
);
	// ----------------------------------------
	// Mode tracking and assertions
	// ----------------------------------------
	logic [31:0]       om, om_q, im, im_q;
	logic [N_BITS-1:0] offm, onm, f0, f1, un;
	wire logic         wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{om, om_q, im, im_q} <= '0;
		end else begin
			{om_q, im_q} <= {om, im};
			if (wr && paddr == `SGM_OUT_MODE_OFF) om <= pwdata;
			if (wr && paddr == `SGM_IN_MODE_OFF) im <= pwdata;
		end
	end
	// A mask bit is set only once the mode has stood for two edges.
	always_comb begin
		for (int i = 0; i < N_BITS; i++) begin
			offm[i] = om[4*i+:4] == 4'h0 && om_q[4*i+:4] == 4'h0;
			onm[i] = om[4*i+:4] == 4'h1 && om_q[4*i+:4] == 4'h1;
			un[i] = im[4*i+:4] == 4'h0 && im_q[4*i+:4] == 4'h0;
			f0[i] = im[4*i+:4] == 4'h4 && im_q[4*i+:4] == 4'h4;
			f1[i] = im[4*i+:4] == 4'h5 && im_q[4*i+:4] == 4'h5;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_oc_level_low: assert property (par_out_o == '0)
		else $error("Open-collector drive level not low.");
	chk_net_fifth_idle: assert property (!net_out_chan[4] && !net_out_chan[9])
		else $error("Fifth network bit driven.");
	chk_net_follows_pins: assert property (net_out_chan[3:0] == par_out_oe[3:0] && net_out_chan[8:5] == par_out_oe[7:4])
		else $error("Network outputs differ from pin outputs.");
	chk_off_quiet: assert property ((par_out_oe & offm) == '0)
		else $error("Output in off mode asserted.");
	chk_on_held: assert property ((par_out_oe & onm) == onm)
		else $error("Output in on mode released.");
	chk_unused_silent: assert property ((remote_out & un) == '0)
		else $error("Unused input sent to far end.");
	chk_force_zero: assert property ((remote_out & f0) == '0)
		else $error("Force-zero bit sent high.");
	chk_force_one: assert property ((remote_out & f1) == f1)
		else $error("Force-one bit sent low.");
	chk_drop_pulse: assert property (call_cmd.disconnect |=> !call_cmd.disconnect)
		else $error("Disconnect request longer than one cycle.");
	chk_dial_pulse: assert property (call_cmd.dial |=> !call_cmd.dial)
		else $error("Dial request longer than one cycle.");
	cover property (call_cmd.dial);
	cover property (call_cmd.disconnect);
	cover property (pslverr);
	cover property ($rose(par_out_oe[7]));
endmodule : sgm_checker

bind sgm_status_gpio_mapper sgm_checker #(.N_BITS(N_BITS)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .par_out_o(par_out_o),
	.par_out_oe(par_out_oe), .net_out_chan(net_out_chan), .remote_out(remote_out), .call_cmd(call_cmd));

// [sgm_far_end.sv]
// Far side model: contact closures with pull-ups and the remote codec.
`timescale 1ns/10ps
module sgm_far_end (
	input  wire logic       pclk,         // Clock.
	input  wire logic       presetn,      // Reset, active low.
	input  wire logic [7:0] close,        // Closures to ground.
	input  wire logic [7:0] far_bits,     // Far-end input bits.
	input  wire logic       far_ok,       // Far end is compatible.
	output logic      [7:0] par_in_n,     // Input pins.
	output logic      [7:0] remote_in,    // Received far bits.
	output logic            remote_valid  // Far end compatible.
);
	// An incompatible far end sends churning bits, not a held value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_in_n <= 8'hFF;
			remote_in <= 8'h00;
			remote_valid <= 1'b0;
		end else begin
			par_in_n <= ~close;
			remote_valid <= far_ok;
			remote_in <= far_ok ? far_bits : ~remote_in;
		end
	end
endmodule : sgm_far_end

// [tb_status_gpio_mapper.sv]
// Testbench for the status GPIO mapper.
`timescale 1ns/10ps
`include "sgm_defines.svh"
module tb_status_gpio_mapper;
	// ----------------------------------------
	// Signals, tasks and tests
	// ----------------------------------------
	logic                   pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]            paddr = '0;
	logic [31:0]            pwdata = '0, prdata, rd;
	logic                   pready, pslverr, sl, remote_valid, far_ok = 1'b0, src;
	logic [7:0]             par_in_n, par_out_o, par_out_oe, remote_in, remote_out, lv;
	logic [7:0]             close = '0, far_bits = '0;
	logic [9:0]             net_in_chan = '0, net_out_chan;
	sgm_pkg::sgm_call_evt_t call_evt = '0;
	sgm_pkg::sgm_call_cmd_t call_cmd;
	int                     num_errors = 0, num_checks = 0, n, nd, nk;
	logic [2:0]             ent;
	sgm_status_gpio_mapper #(.PULSE_CYC(4), .PERIOD_CYC(50)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .par_in_n(par_in_n), .par_out_o(par_out_o), .par_out_oe(par_out_oe),
		.net_in_chan(net_in_chan), .net_out_chan(net_out_chan), .call_evt(call_evt), .remote_in(remote_in),
		.remote_valid(remote_valid), .remote_out(remote_out), .call_cmd(call_cmd));
	sgm_far_end far (.pclk(pclk), .presetn(presetn), .close(close), .far_bits(far_bits), .far_ok(far_ok),
		.par_in_n(par_in_n), .remote_in(remote_in), .remote_valid(remote_valid));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic evt(input logic [5:0] v);
		@(posedge pclk);
		call_evt <= v;
		@(posedge pclk);
		call_evt <= v & 6'h38;
	endtask : evt
	task automatic watch();
		nd = 0;
		nk = 0;
		repeat (10) begin
			@(posedge pclk);
			nd += call_cmd.disconnect;
			nk += call_cmd.dial;
			if (call_cmd.dial) ent = call_cmd.dial_entry;
		end
	endtask : watch
	function automatic logic [5:0] exp_lo(input sgm_pkg::sgm_call_evt_t e, input logic m, input logic f);
		return {f, e.connected & e.codec_known & e.rx_valid, e.connected, m & e.connected, 2'b10};
	endfunction : exp_lo
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(99));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(0, `SGM_OUT_MODE_OFF, 0);
		chk("out_modes", 0, rd);
		xfer(0, `SGM_THRESH_OFF, 0);
		chk("thresh", 32'h10, rd);
		xfer(0, 12'h020, 0);
		chk("slverr", 1, sl);
		xfer(1, `SGM_OUT_MODE_OFF, 32'h7654_3210);
		xfer(1, `SGM_IN_MODE_OFF, 32'h1111_1111);
		for (int k = 0; k < 24; k++) begin
			src = 1'($urandom);
			close <= 8'($urandom);
			net_in_chan <= 10'($urandom);
			far_bits <= 8'($urandom);
			far_ok <= 1'($urandom);
			call_evt <= {3'($urandom), 3'h0};
			xfer(1, `SGM_CTRL_OFF, {31'h0, src});
			repeat (6) @(posedge pclk);
			lv = src ? {net_in_chan[8:5], net_in_chan[3:0]} : close;
			chk("remote_out", lv, remote_out);
			chk("out_low", exp_lo(call_evt, far_bits[2] & far_ok, lv[5]), par_out_oe[5:0]);
		end
		xfer(1, `SGM_CTRL_OFF, 0);
		evt(6'h04);
		repeat (4) @(posedge pclk);
		chk("drop_set", 1, par_out_oe[6]);
		xfer(0, `SGM_STATUS_OFF, 0);
		chk("status_drop", 1, rd[2]);
		xfer(1, `SGM_CTRL_OFF, 32'h2);
		repeat (3) @(posedge pclk);
		chk("drop_cancel", 0, par_out_oe[6]);
		evt(6'h04);
		evt(6'h20);
		repeat (3) @(posedge pclk);
		chk("drop_reconnect", 0, par_out_oe[6]);
		evt(6'h22);
		n = 0;
		repeat (12) begin
			@(posedge pclk);
			n += par_out_oe[7];
		end
		chk("loss_len", 4, n);
		xfer(1, `SGM_OUT_MODE_OFF, 32'h8654_3210);
		xfer(1, `SGM_THRESH_OFF, 2);
		evt(6'h21);
		repeat (120) @(posedge pclk);
		chk("poor_below", 0, par_out_oe[7]);
		repeat (4) evt(6'h23);
		n = 0;
		while (par_out_oe[7] !== 1'b1 && n < 120) begin
			@(posedge pclk);
			n++;
		end
		chk("poor_rise", 1, par_out_oe[7]);
		repeat (25) @(posedge pclk);
		chk("poor_held", 1, par_out_oe[7]);
		repeat (85) @(posedge pclk);
		chk("poor_clear", 0, par_out_oe[7]);
		xfer(1, `SGM_IN_MODE_OFF, 32'h0054_3002);
		close <= 8'h12;
		watch();
		chk("unused_cmds", 0, nd + nk);
		chk("force_bits", 8'h20, remote_out & 8'h32);
		close <= 8'h13;
		watch();
		chk("disconnect", 1, nd);
		close <= 8'h1B;
		watch();
		chk("dial", 1, nk);
		chk("dial_entry", 3, ent);
		wrap_up();
	end
endmodule : tb_status_gpio_mapper
